// *** verilog/dsmc_pkg.sv ***
// Package of constants for the dual switch mode controller
`default_nettype none
package dsmc_pkg;
	// ----------------------------------------
	// Operating modes
	// ----------------------------------------
	typedef enum logic [1:0] {
		DSMC_SLEEP    = 2'b00,
		DSMC_NORMAL   = 2'b01,
		DSMC_FAILSAFE = 2'b10,
		DSMC_FAULT    = 2'b11
	} dsmc_mode_t;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_MHZ          = 125;
	localparam int WAKE_READY_US    = 50;
	localparam int WD_TIMEOUT_MS    = 310;
	localparam int IN_TIMEOUT_MS    = 250;
	localparam int WAKE_READY_CYC   = WAKE_READY_US * CLK_MHZ;
	localparam int WD_TIMEOUT_CYC   = WD_TIMEOUT_MS * 1000 * CLK_MHZ;
	localparam int IN_TIMEOUT_CYC   = IN_TIMEOUT_MS * 1000 * CLK_MHZ;
	localparam int CNT_W            = 32;

	// ----------------------------------------
	// Register fields
	// ----------------------------------------
	localparam int GCR_WATCHDOG_DISABLE_BIT   = 4;
	localparam int DUTY_MSB         = 7;
	localparam int DUTY_LSB         = 0;
	localparam int DUTY_W           = DUTY_MSB - DUTY_LSB + 1;
	localparam int PRESC_W          = 8;
	localparam int NUM_CH           = 2;
	localparam logic [7:0] GCR_RST  = 8'h00;
endpackage : dsmc_pkg
`default_nettype wire

// *** verilog/dsmc_top.sv ***
// Operating-mode controller for a dual-channel power switch
`timescale 1ns/10ps
`default_nettype none
module dsmc_top #(
	parameter int WD_TIMEOUT_CYC = dsmc_pkg::WD_TIMEOUT_CYC,
	parameter int IN_TIMEOUT_CYC = dsmc_pkg::IN_TIMEOUT_CYC,
	parameter int WAKE_READY_CYC = dsmc_pkg::WAKE_READY_CYC
) (
	// Clock and reset
	input  wire logic                     core_clk_in,
	input  wire logic                     rstn_in,
	// Host pins
	input  wire logic                     reset_line_n_in,
	input  wire logic [1:0]               direct_in_in,
	input  wire logic                     ext_clk_in,
	// Received serial word events
	input  wire logic                     word_valid_in,
	input  wire logic                     watchdog_toggle_bit_in,
	// Supplies and protections
	input  wire logic                     supply_ok_in,
	input  wire logic                     logic_supply_ok_in,
	input  wire logic                     supply_fail_enable_in,
	input  wire logic [1:0]               overcurrent_fault_in,
	input  wire logic [1:0]               overtemperature_fault_in,
	input  wire logic [1:0]               severe_short_fault_in,
	input  wire logic                     undervoltage_fault_in,
	input  wire logic                     overvoltage_fault_in,
	input  wire logic                     overvoltage_detect_enable_in,
	// Register port
	input  wire logic [3:0]               reg_addr_in,
	input  wire logic [7:0]               reg_wdata_in,
	input  wire logic                     reg_wr_in,
	input  wire logic                     reg_rd_in,
	output logic      [7:0]               reg_rdata_out,
	// Status and channel outputs
	output logic      [1:0]               mode_out,
	output logic                          normal_mode_flag_out,
	output logic                          ready_out,
	output logic                          failsafe_output_n_out,
	output logic                          delatch_out,
	output logic      [1:0]               hson_out
);
	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [3:0] A_GCR   = 4'h0;
	localparam logic [3:0] A_PWM0  = 4'h1;
	localparam logic [3:0] A_PWM1  = 4'h2;
	localparam logic [3:0] A_CFG0  = 4'h3;
	localparam logic [3:0] A_CFG1  = 4'h4;
	localparam logic [3:0] A_STAT  = 4'h5;
	localparam int CFG_ON  = 0;
	localparam int CFG_PWM = 1;
	localparam int CFG_DIR = 2;
	localparam int CFG_EXT = 3;
	localparam logic [7:0] ZERO8 = 8'h00;

	dsmc_pkg::dsmc_mode_t mode_r;
	logic [7:0]  global_config_register_r;
	logic [7:0]  pulse_width_register_r [2];
	logic [7:0]  channel_config_register_r [2];
	logic [7:0]  pwm_prescaler_r [2];
	logic [31:0] wd_cnt_r;
	logic [31:0] in_cnt_r [2];
	logic [31:0] ready_cnt_r;
	logic [1:0]  in_on_r;
	logic [1:0]  in_prev_r;
	logic        rst_prev_r, ext_prev_r, wd_bit_prev_r, wd_expired_r;
	logic        lsup_seen_r, fs_exit_armed_r, regs_locked_r;
	logic        wake_up, fail_safe, fault, watchdog_disable;
	logic        wd_run, wake_evt, wr_ok, ext_rise;
	dsmc_pkg::dsmc_mode_t mode_nxt;

	// ----------------------------------------
	// Mode terms
	// ----------------------------------------
	assign watchdog_disable    = global_config_register_r[dsmc_pkg::GCR_WATCHDOG_DISABLE_BIT];
	assign wake_up   = reset_line_n_in | in_on_r[0] | in_on_r[1];
	assign fail_safe = (wd_expired_r & ~watchdog_disable)
	                 | (lsup_seen_r & ~logic_supply_ok_in & supply_fail_enable_in);
	assign fault     = (|overcurrent_fault_in) | (|overtemperature_fault_in)
	                 | (|severe_short_fault_in) | undervoltage_fault_in
	                 | (overvoltage_fault_in & overvoltage_detect_enable_in);
	assign wake_evt  = (reset_line_n_in & ~rst_prev_r & logic_supply_ok_in)
	                 | (|(direct_in_in & ~in_prev_r));
	assign wd_run    = (mode_r == dsmc_pkg::DSMC_NORMAL) & logic_supply_ok_in
	                 & ~watchdog_disable & reset_line_n_in;
	assign ext_rise  = ext_clk_in & ~ext_prev_r;

	// Sleep wins, then fault, then fail-safe; Normal needs supplies in range
	always_comb begin
		if (!wake_up) begin
			mode_nxt = dsmc_pkg::DSMC_SLEEP;
		end else if (fault) begin
			mode_nxt = dsmc_pkg::DSMC_FAULT;
		end else if (fail_safe) begin
			mode_nxt = dsmc_pkg::DSMC_FAILSAFE;
		end else if (supply_ok_in) begin
			mode_nxt = dsmc_pkg::DSMC_NORMAL;
		end else begin
			mode_nxt = mode_r;
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (!rstn_in) begin
			mode_r <= dsmc_pkg::DSMC_SLEEP;
		end else begin
			mode_r <= mode_nxt;
		end
	end

	// ----------------------------------------
	// Edge history
	// ----------------------------------------
	always_ff @(posedge core_clk_in) begin
		if (!rstn_in) begin
			rst_prev_r <= 1'b0;
			in_prev_r  <= 2'b00;
			ext_prev_r <= 1'b0;
			lsup_seen_r <= 1'b0;
		end else begin
			rst_prev_r <= reset_line_n_in;
			in_prev_r  <= direct_in_in;
			ext_prev_r <= ext_clk_in;
			if (logic_supply_ok_in) begin
				lsup_seen_r <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// Direct-input activity timeouts
	// ----------------------------------------
	for (genvar c = 0; c < dsmc_pkg::NUM_CH; c++) begin : g_act
		always_ff @(posedge core_clk_in) begin
			if (!rstn_in) begin
				in_cnt_r[c] <= '0;
				in_on_r[c]  <= 1'b0;
			end else if (direct_in_in[c]) begin
				in_cnt_r[c] <= '0;
				in_on_r[c]  <= 1'b1;
			end else if (in_on_r[c]) begin
				if (in_cnt_r[c] >= 32'(IN_TIMEOUT_CYC)) begin
					in_on_r[c] <= 1'b0;
				end else begin
					in_cnt_r[c] <= in_cnt_r[c] + 32'h0000_0001;
				end
			end
		end
	end

	// ----------------------------------------
	// Serial-link watchdog
	// ----------------------------------------
	// Restarted by a wake event so a fresh reset-line rise starts a full window
	always_ff @(posedge core_clk_in) begin
		if (!rstn_in) begin
			wd_cnt_r      <= '0;
			wd_expired_r  <= 1'b0;
			wd_bit_prev_r <= 1'b0;
		end else begin
			if (word_valid_in) begin
				wd_bit_prev_r <= watchdog_toggle_bit_in;
			end
			if (mode_r == dsmc_pkg::DSMC_FAILSAFE) begin
				wd_cnt_r <= '0;
				if (fs_exit_armed_r && word_valid_in) begin
					wd_expired_r <= 1'b0;
				end
			end else if (wake_evt
			             || (word_valid_in && watchdog_toggle_bit_in != wd_bit_prev_r)) begin
				wd_cnt_r <= '0;
			end else if (wd_run) begin
				if (wd_cnt_r >= 32'(WD_TIMEOUT_CYC)) begin
					wd_expired_r <= 1'b1;
				end else begin
					wd_cnt_r <= wd_cnt_r + 32'h0000_0001;
				end
			end
		end
	end

	// Exit from fail-safe: first word with the bit set arms, second within timeout clears
	logic [31:0] fs_cnt_r;
	always_ff @(posedge core_clk_in) begin
		if (!rstn_in) begin
			fs_exit_armed_r <= 1'b0;
			fs_cnt_r        <= '0;
		end else if (mode_r != dsmc_pkg::DSMC_FAILSAFE) begin
			fs_exit_armed_r <= 1'b0;
			fs_cnt_r        <= '0;
		end else if (fs_exit_armed_r && word_valid_in) begin
			fs_exit_armed_r <= 1'b0;
		end else if (!fs_exit_armed_r && word_valid_in && watchdog_toggle_bit_in) begin
			fs_exit_armed_r <= 1'b1;
			fs_cnt_r        <= '0;
		end else if (fs_exit_armed_r) begin
			if (fs_cnt_r >= 32'(WD_TIMEOUT_CYC)) begin
				fs_exit_armed_r <= 1'b0;
			end else begin
				fs_cnt_r <= fs_cnt_r + 32'h0000_0001;
			end
		end
	end

	// ----------------------------------------
	// Wake readiness delay
	// ----------------------------------------
	always_ff @(posedge core_clk_in) begin
		if (!rstn_in || mode_r == dsmc_pkg::DSMC_SLEEP) begin
			ready_cnt_r <= '0;
			ready_out   <= 1'b0;
		end else if (ready_cnt_r >= 32'(WAKE_READY_CYC)) begin
			ready_out <= 1'b1;
		end else begin
			ready_cnt_r <= ready_cnt_r + 32'h0000_0001;
		end
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	// Registers are locked from fail-safe entry until the mode is back in Normal
	always_ff @(posedge core_clk_in) begin
		if (!rstn_in) begin
			regs_locked_r <= 1'b0;
		end else if (mode_nxt == dsmc_pkg::DSMC_FAILSAFE) begin
			regs_locked_r <= 1'b1;
		end else if (mode_r == dsmc_pkg::DSMC_NORMAL) begin
			regs_locked_r <= 1'b0;
		end
	end

	assign wr_ok = reg_wr_in & ~regs_locked_r & reset_line_n_in & ready_out;

	// Sleep, reset line low and fail-safe entry all return the map to defaults
	logic regs_clear;
	assign regs_clear = (mode_r == dsmc_pkg::DSMC_SLEEP) || !reset_line_n_in
	                  || (mode_r != dsmc_pkg::DSMC_FAILSAFE && mode_nxt == dsmc_pkg::DSMC_FAILSAFE);

	always_ff @(posedge core_clk_in) begin
		if (!rstn_in || regs_clear) begin
			global_config_register_r <= dsmc_pkg::GCR_RST;
			for (int i = 0; i < dsmc_pkg::NUM_CH; i++) begin
				pulse_width_register_r[i]    <= ZERO8;
				channel_config_register_r[i] <= ZERO8;
			end
		end else if (wr_ok) begin
			unique case (reg_addr_in)
				A_GCR:   global_config_register_r     <= reg_wdata_in;
				A_PWM0:  pulse_width_register_r[0]    <= reg_wdata_in;
				A_PWM1:  pulse_width_register_r[1]    <= reg_wdata_in;
				A_CFG0:  channel_config_register_r[0] <= reg_wdata_in;
				A_CFG1:  channel_config_register_r[1] <= reg_wdata_in;
				default: ;
			endcase
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (!rstn_in || !reg_rd_in) begin
			reg_rdata_out <= ZERO8;
		end else begin
			unique case (reg_addr_in)
				A_GCR:   reg_rdata_out <= global_config_register_r;
				A_PWM0:  reg_rdata_out <= pulse_width_register_r[0];
				A_PWM1:  reg_rdata_out <= pulse_width_register_r[1];
				A_CFG0:  reg_rdata_out <= channel_config_register_r[0];
				A_CFG1:  reg_rdata_out <= channel_config_register_r[1];
				A_STAT:  reg_rdata_out <= {2'b00, in_on_r, regs_locked_r, ready_out, mode_r};
				default: reg_rdata_out <= ZERO8;
			endcase
		end
	end

	// ----------------------------------------
	// PWM and channel targets
	// ----------------------------------------
	// Period is 256 ticks of the prescaled core clock or of the external clock
	for (genvar c = 0; c < dsmc_pkg::NUM_CH; c++) begin : g_ch
		logic [7:0] phase_r;
		logic       tick;
		logic       duty_on;
		logic       direct_only;
		logic       target;
		always_ff @(posedge core_clk_in) begin
			if (!rstn_in) begin
				pwm_prescaler_r[c] <= ZERO8;
			end else if (tick || channel_config_register_r[c][CFG_EXT]) begin
				pwm_prescaler_r[c] <= ZERO8;
			end else begin
				pwm_prescaler_r[c] <= pwm_prescaler_r[c] + 8'h01;
			end
		end
		assign tick = channel_config_register_r[c][CFG_EXT] ? ext_rise
		            : (pwm_prescaler_r[c] == 8'hFF);
		always_ff @(posedge core_clk_in) begin
			if (!rstn_in) begin
				phase_r <= ZERO8;
			end else if (tick) begin
				phase_r <= phase_r + 8'h01;
			end
		end
		assign duty_on = phase_r < pulse_width_register_r[c][dsmc_pkg::DUTY_MSB:dsmc_pkg::DUTY_LSB];
		assign direct_only = !reset_line_n_in || mode_r == dsmc_pkg::DSMC_FAILSAFE;
		always_comb begin
			if (direct_only) begin
				target = direct_in_in[c];
			end else begin
				target = (direct_in_in[c] & ~channel_config_register_r[c][CFG_DIR])
				       | (channel_config_register_r[c][CFG_ON] & duty_on & channel_config_register_r[c][CFG_PWM])
				       | (channel_config_register_r[c][CFG_ON] & ~channel_config_register_r[c][CFG_PWM]);
			end
		end
		always_ff @(posedge core_clk_in) begin
			if (!rstn_in) begin
				hson_out[c] <= 1'b0;
			end else begin
				hson_out[c] <= target & (mode_r == dsmc_pkg::DSMC_NORMAL
				                       || mode_r == dsmc_pkg::DSMC_FAILSAFE);
			end
		end
	end

	// ----------------------------------------
	// Status outputs
	// ----------------------------------------
	always_ff @(posedge core_clk_in) begin
		if (!rstn_in) begin
			failsafe_output_n_out <= 1'b1;
			delatch_out           <= 1'b0;
		end else begin
			failsafe_output_n_out <= ~(mode_nxt == dsmc_pkg::DSMC_FAILSAFE);
			delatch_out <= (mode_r != dsmc_pkg::DSMC_FAILSAFE) && (mode_nxt == dsmc_pkg::DSMC_FAILSAFE);
		end
	end

	assign mode_out             = mode_r;
	assign normal_mode_flag_out = (mode_r == dsmc_pkg::DSMC_NORMAL);
endmodule : dsmc_top
`default_nettype wire

// *** verif/dsmc_host.sv ***
// Host microcontroller model: reset line, direct inputs and received serial words
`timescale 1ns/10ps
`default_nettype none
module dsmc_host (
	// Clock
	input  wire logic       clk_in,
	// Host pins
	output var logic        reset_line_n_out,
	output var logic [1:0]  direct_out,
	// Serial word events
	output var logic        word_valid_out,
	output var logic        wd_bit_out
);
	logic wd_last;
	initial begin
		reset_line_n_out = 1'b0;
		direct_out = 2'b00;
		word_valid_out = 1'b0;
		wd_bit_out = 1'b0;
		wd_last = 1'b0;
	end
	// One word; the bit is inverted outside the word so a stale value never looks valid
	task automatic send_word(input logic b);
		@(posedge clk_in);
		word_valid_out <= 1'b1;
		wd_bit_out <= b;
		@(posedge clk_in);
		word_valid_out <= 1'b0;
		wd_bit_out <= ~b;
		wd_last = b;
	endtask : send_word
	task automatic keep_alive(input int n, input int gap);
		for (int i = 0; i < n; i++) begin
			send_word(~wd_last);
			repeat (gap) @(posedge clk_in);
		end
	endtask : keep_alive
	task automatic leave_failsafe();
		send_word(1'b1);
		repeat (4) @(posedge clk_in);
		send_word(1'b0);
	endtask : leave_failsafe
	task automatic set_pins(input logic rl, input logic [1:0] d);
		@(posedge clk_in);
		reset_line_n_out <= rl;
		direct_out <= d;
	endtask : set_pins
endmodule : dsmc_host
`default_nettype wire

// *** verif/dsmc_chk.sv ***
// Checker for the mode and channel outputs of the dual switch mode controller
`timescale 1ns/10ps
`default_nettype none
module dsmc_chk #(
	parameter int IN_TIMEOUT_CYC = dsmc_pkg::IN_TIMEOUT_CYC
) (
	// Clock and reset
	input wire logic       core_clk_in,
	input wire logic       rstn_in,
	// Host pins, supplies and protections
	input wire logic       reset_line_n_in,
	input wire logic [1:0] direct_in_in,
	input wire logic       supply_ok_in,
	input wire logic [1:0] overcurrent_fault_in,
	input wire logic [1:0] overtemperature_fault_in,
	input wire logic [1:0] severe_short_fault_in,
	input wire logic       undervoltage_fault_in,
	input wire logic       overvoltage_fault_in,
	input wire logic       overvoltage_detect_enable_in,
	// Outputs under watch
	input wire logic [1:0] mode_out,
	input wire logic       normal_mode_flag_out,
	input wire logic       failsafe_output_n_out,
	input wire logic       delatch_out,
	input wire logic [1:0] hson_out
);
	localparam logic [1:0] M_SL = dsmc_pkg::DSMC_SLEEP;
	localparam logic [1:0] M_NM = dsmc_pkg::DSMC_NORMAL;
	localparam logic [1:0] M_FS = dsmc_pkg::DSMC_FAILSAFE;
	localparam logic [1:0] M_FT = dsmc_pkg::DSMC_FAULT;
	default clocking cb @(posedge core_clk_in);
	endclocking
	default disable iff (!rstn_in);
	wire logic flt = (|overcurrent_fault_in) | (|overtemperature_fault_in) | (|severe_short_fault_in)
		| undervoltage_fault_in | (overvoltage_fault_in & overvoltage_detect_enable_in);
	wire logic dctl = (!reset_line_n_in || mode_out == M_FS) && mode_out != M_SL && mode_out != M_FT;
	// Quiet time with reset line low and inputs off; saturates so the counter stays small
	int unsigned quiet_r;
	always_ff @(posedge core_clk_in) begin
		if (!rstn_in || reset_line_n_in || direct_in_in != 2'b00)
			quiet_r <= '0;
		else if (quiet_r < 1000)
			quiet_r <= quiet_r + 1;
	end
	sequence s_fault_held;
		(flt && reset_line_n_in) [*2];
	endsequence
	sequence s_direct_held;
		dctl [*3] ##0 $stable(direct_in_in);
	endsequence
	property p_flag;
		normal_mode_flag_out == (mode_out == M_NM);
	endproperty
	a_flag: assert property (p_flag) else $error("normal flag disagrees with mode");
	property p_fs_pin;
		failsafe_output_n_out == (mode_out != M_FS);
	endproperty
	a_fs_pin: assert property (p_fs_pin) else $error("fail-safe pin disagrees with mode");
	property p_sleep_off;
		(mode_out == M_SL) [*2] |-> hson_out == 2'b00;
	endproperty
	a_sleep_off: assert property (p_sleep_off) else $error("channel on in sleep");
	property p_fault_off;
		(mode_out == M_FT) [*2] |-> hson_out == 2'b00;
	endproperty
	a_fault_off: assert property (p_fault_off) else $error("channel on in fault");
	property p_fault_entry;
		s_fault_held |-> mode_out == M_FT;
	endproperty
	a_fault_entry: assert property (p_fault_entry) else $error("fault term did not give fault mode");
	property p_wake;
		(reset_line_n_in && supply_ok_in) [*2] |-> mode_out != M_SL;
	endproperty
	a_wake: assert property (p_wake) else $error("asleep with reset line high");
	property p_active;
		(direct_in_in != 2'b00 && supply_ok_in) [*3] |-> mode_out != M_SL;
	endproperty
	a_active: assert property (p_active) else $error("asleep with a direct input active");
	property p_sleep;
		quiet_r > IN_TIMEOUT_CYC + 3 |-> mode_out == M_SL;
	endproperty
	a_sleep: assert property (p_sleep) else $error("not asleep after input timeout");
	property p_direct;
		s_direct_held |-> hson_out == direct_in_in;
	endproperty
	a_direct: assert property (p_direct) else $error("channels not following direct inputs");
	property p_delatch_mode;
		delatch_out |-> ##[0:1] (mode_out == M_FS);
	endproperty
	a_delatch_mode: assert property (p_delatch_mode) else $error("delatch away from fail-safe entry");
	property p_delatch_pulse;
		delatch_out |=> !delatch_out;
	endproperty
	a_delatch_pulse: assert property (p_delatch_pulse) else $error("delatch longer than one cycle");
endmodule : dsmc_chk
bind dsmc_top dsmc_chk #(.IN_TIMEOUT_CYC(IN_TIMEOUT_CYC)) u_chk (.core_clk_in, .rstn_in, .reset_line_n_in,
	.direct_in_in, .supply_ok_in, .overcurrent_fault_in, .overtemperature_fault_in, .severe_short_fault_in,
	.undervoltage_fault_in, .overvoltage_fault_in, .overvoltage_detect_enable_in, .mode_out,
	.normal_mode_flag_out, .failsafe_output_n_out, .delatch_out, .hson_out);
`default_nettype wire

// *** verif/dsmc_top_tb.sv ***
// Self-checking testbench for the dual switch mode controller
`timescale 1ns/10ps
`default_nettype none
module dsmc_top_tb;
	localparam int WD = 50;
	localparam int IN = 40;
	localparam int WK = 10;
	localparam logic [1:0] SL = dsmc_pkg::DSMC_SLEEP;
	localparam logic [1:0] NM = dsmc_pkg::DSMC_NORMAL;
	localparam logic [1:0] FS = dsmc_pkg::DSMC_FAILSAFE;
	localparam logic [1:0] FT = dsmc_pkg::DSMC_FAULT;
	logic       core_clk_in, rstn_in, reset_line_n_in, ext_clk_in, word_valid_in, watchdog_toggle_bit_in;
	logic       supply_ok_in, logic_supply_ok_in, supply_fail_enable_in, undervoltage_fault_in;
	logic       overvoltage_fault_in, overvoltage_detect_enable_in, reg_wr_in, reg_rd_in;
	logic [1:0] direct_in_in, overcurrent_fault_in, overtemperature_fault_in, severe_short_fault_in;
	logic [1:0] mode_out, hson_out;
	logic       normal_mode_flag_out, ready_out, failsafe_output_n_out, delatch_out;
	logic [3:0] reg_addr_in;
	logic [7:0] reg_wdata_in, reg_rdata_out, d;
	logic [8:0] fv;
	int         n_mismatch, checked, n_delatch, nh, n0, cls;
	logic [7:0] pw_t [6] = '{8'h00, 8'hFF, 8'h80, 8'h00, 8'h00, 8'h00};
	logic [7:0] cf_t [6] = '{8'h03, 8'h03, 8'h0B, 8'h01, 8'h04, 8'h00};
	int         ex_t [6] = '{0, 3, 1, 2, 0, 2};
	logic [5:0] dr_t = 6'h30;
	assign {overvoltage_detect_enable_in, overvoltage_fault_in, undervoltage_fault_in} = fv[8:6];
	assign {severe_short_fault_in, overtemperature_fault_in, overcurrent_fault_in} = fv[5:0];
	dsmc_top #(.WD_TIMEOUT_CYC(WD), .IN_TIMEOUT_CYC(IN), .WAKE_READY_CYC(WK)) dut (.*);
	dsmc_host host (
		.clk_in           (core_clk_in),
		.reset_line_n_out (reset_line_n_in),
		.direct_out       (direct_in_in),
		.word_valid_out   (word_valid_in),
		.wd_bit_out       (watchdog_toggle_bit_in)
	);
	always #4 core_clk_in = ~core_clk_in;
	always @(posedge core_clk_in) ext_clk_in <= ~ext_clk_in;
	always @(posedge core_clk_in) if (delatch_out === 1'b1) n_delatch++;
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string m);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
		end
	endtask : chk8
	task automatic complete_run();
		$display("checked %0d, mismatched %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : complete_run
	task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] v);
		@(posedge core_clk_in);
		reg_wr_in <= w;
		reg_rd_in <= !w;
		reg_addr_in <= a;
		reg_wdata_in <= v;
		@(posedge core_clk_in);
		reg_wr_in <= 1'b0;
		reg_rd_in <= 1'b0;
		#1 d = reg_rdata_out;
	endtask : bus
	task automatic rdchk(input logic [3:0] a, input logic [7:0] exp, input string m);
		bus(1'b0, a, 8'h00);
		chk8(d, exp, m);
	endtask : rdchk
	task automatic step(input int n);
		repeat (n) @(posedge core_clk_in);
		#1;
	endtask : step
	task automatic wait_mode(input logic [1:0] m, input int bound);
		int i;
		for (i = 0; i < bound; i++) begin
			step(1);
			if (mode_out === m)
				break;
		end
		if (i == bound) begin
			n_mismatch++;
			$display("wrong value at %0t: mode wait ran out", $time);
			complete_run();
		end
	endtask : wait_mode
	initial begin
		{core_clk_in, rstn_in, ext_clk_in, supply_fail_enable_in, reg_wr_in, reg_rd_in} = '0;
		{supply_ok_in, logic_supply_ok_in} = 2'h3;
		{reg_addr_in, reg_wdata_in} = '0;
		fv = 9'h100;
		repeat (10) @(posedge core_clk_in);
		rstn_in <= 1'b1;
		step(1);
		chk8({mode_out, failsafe_output_n_out, hson_out}, 8'h04, "state after reset");
		supply_ok_in <= 1'b0;
		host.set_pins(1'b1, 2'b00);
		step(3);
		chk8(mode_out, SL, "woke with supplies out of range");
		supply_ok_in <= 1'b1;
		wait_mode(NM, 3);
		chk8(ready_out, 1'b0, "ready too early");
		step(WK + 2);
		chk8(ready_out, 1'b1, "ready late");
		rdchk(4'h5, 8'h05, "status");
		rdchk(4'h1, 8'h00, "pulse width cleared");
		rdchk(4'hF, 8'h00, "unmapped read");
		$display("end of test: wake");
		host.keep_alive(4, WD - 20);
		step(0);
		chk8(mode_out, NM, "link kept");
		bus(1'b1, 4'h0, 8'h10);
		rdchk(4'h0, 8'h10, "watchdog disable");
		step(3 * WD);
		chk8(mode_out, NM, "watchdog off");
		// Slow direct-input traffic runs with the reset line held high
		for (int k = 0; k < 6; k++) begin
			host.set_pins(1'b1, {dr_t[k], 1'b0});
			bus(1'b1, 4'h2, pw_t[k]);
			bus(1'b1, 4'h4, cf_t[k]);
			step(2);
			nh = 0;
			n0 = 0;
			repeat (2200) begin
				step(1);
				nh += int'(hson_out[1] === 1'b1);
				n0 += int'(hson_out[0] !== 1'b0);
			end
			cls = (ex_t[k] == 3 && nh > 0) ? 3 : (nh == 0) ? 0 : (nh == 2200) ? 2 : 1;
			chk8(8'(cls), 8'(ex_t[k]), "channel 1 target");
			chk8(8'(n0 > 0), 8'h00, "channel 0 moved");
		end
		bus(1'b1, 4'h4, 8'h00);
		$display("end of test: channel targets");
		host.set_pins(1'b1, 2'b11);
		for (int i = 0; i < 9; i++) begin
			@(posedge core_clk_in);
			fv <= (i < 7) ? 9'(1 << i) : (i == 7) ? 9'h180 : 9'h080;
			step(3);
			chk8({mode_out, hson_out}, (i == 8) ? {NM, 2'b11} : {FT, 2'b00}, "fault term");
			@(posedge core_clk_in);
			fv <= 9'h100;
			step(3);
		end
		$display("end of test: faults");
		host.set_pins(1'b1, 2'b00);
		bus(1'b1, 4'h0, 8'h00);
		wait_mode(FS, WD + 10);
		// The delatch pulse launched with the mode change is only counted at the following edge
		step(1);
		chk8({failsafe_output_n_out, 7'(n_delatch > 0)}, 8'h01, "fail-safe pin, delatch");
		host.set_pins(1'b1, 2'b10);
		step(3);
		chk8(hson_out, 2'b10, "fail-safe direct control");
		bus(1'b1, 4'h4, 8'h01);
		rdchk(4'h4, 8'h00, "write while locked");
		host.leave_failsafe();
		wait_mode(NM, 10);
		bus(1'b1, 4'h4, 8'h01);
		rdchk(4'h4, 8'h01, "write after exit");
		@(posedge core_clk_in);
		supply_fail_enable_in <= 1'b1;
		logic_supply_ok_in <= 1'b0;
		wait_mode(FS, 5);
		$display("end of test: fail-safe");
		host.set_pins(1'b0, 2'b01);
		step(5);
		host.set_pins(1'b0, 2'b00);
		step(IN - 5);
		chk8(mode_out === SL, 1'b0, "slept before timeout");
		wait_mode(SL, 15);
		step(8);
		chk8(hson_out, 2'b00, "sleep outputs");
		host.set_pins(1'b0, 2'b01);
		step(3);
		chk8({mode_out === SL, hson_out}, 8'h01, "direct wake");
		$display("end of test: sleep");
		complete_run();
	end
endmodule : dsmc_top_tb
`default_nettype wire
